/* logic/cpu_register_set.sv */
// programmer-visible register set, status word, stack and vector sequencer
// assumes a wishbone master on clk_sys, a synchronous program rom with one cycle latency
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module cpu_register_set (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone slave
    input wire cpu_regs_pkg::wb_req_s wbReq,
    output cpu_regs_pkg::wb_rsp_s wbRsp,
    // program memory read port
    output logic [15:0] progAddr,
    output logic progRead,
    input wire logic [7:0] progData,
    // external interrupt pins and status
    input wire logic [1:0] extIrq,
    output logic busy
);
    import cpu_regs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] acc;
    logic [7:0] xIdx;
    logic [7:0] yIdx;
    logic [7:0] sp;
    logic [15:0] pc;
    psw_s processor_status_word;
    psw_s savedPsw;
    logic [15:0] opnd;
    logic [15:0] ea;
    logic [8:0] ramAdr;
    logic [7:0] ram [0:DMEM_BYTES-1];
    state_e state;
    logic [1:0] pushIdx;
    logic [1:0] pushLast;
    logic useVec;
    logic [15:0] target;
    logic [1:0] irqMeta;
    logic [1:0] irqLevel;
    logic ack;
    logic [31:0] rdData;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic wbWr;
    logic regWr;
    logic cmdFire;
    cmd_e cmdCode;
    logic [3:0] tcallSlot;
    logic irqTake;
    logic [15:0] irqVec;
    logic [15:0] tcallVec;
    logic isCall;
    logic callStart;
    logic [7:0] pushByte;
    logic ramInRange;
    logic [31:0] next_rdData;
    alu_op_e aluOp;
    logic [7:0] aluRes;
    logic aluC;
    logic aluH;
    logic aluV;

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : lane16

    assign busy = (state != ST_IDLE);
    assign wbWr = wbReq.cyc && wbReq.stb && wbReq.we && !ack;
    assign regWr = wbWr && !busy && wbReq.sel[0];
    assign cmdFire = regWr && (wbReq.adr == OFF_CMD);
    assign cmdCode = cmd_e'(wbReq.dat[CMD_CODE_LSB +: 5]);
    assign tcallSlot = wbReq.dat[CMD_SLOT_LSB +: 4];
    assign irqTake = !busy && !cmdFire && processor_status_word.i && (irqLevel != 2'b00);
    assign irqVec = EXT0_VEC - {14'h0000, !irqLevel[0], 1'b0};
    assign tcallVec = TABLE_CALL_OP_SLOT0_VEC - {11'h000, tcallSlot, 1'b0};
    assign isCall = cmdFire && (cmdCode == CMD_CALL || cmdCode == CMD_PAGE_CALL_OP || cmdCode == CMD_TABLE_CALL_OP
                                || cmdCode == CMD_BRK);
    assign callStart = isCall || irqTake;
    assign pushByte = (pushIdx == 2'd0) ? pc[15:8] : (pushIdx == 2'd1) ? pc[7:0] : savedPsw;
    assign ramInRange = (ramAdr < 9'(DMEM_BYTES));
    assign progRead = (state == ST_VEC_LO) || (state == ST_VEC_HI);
    assign wbRsp.ack = ack;
    assign wbRsp.dat = rdData;

    always_comb begin
        case (cmdCode)
            CMD_ADD: aluOp = ALU_ADD;
            CMD_SUB: aluOp = ALU_SUB;
            CMD_SHL: aluOp = ALU_SHL;
            CMD_ROL: aluOp = ALU_ROL;
            default: aluOp = ALU_PASS;
        endcase
    end

    alu_flag_unit u_alu (
        .aluOp(aluOp),
        .opA(acc),
        .opB(opnd[7:0]),
        .carryIn(processor_status_word.c),
        .result(aluRes),
        .carryOut(aluC),
        .halfCarry(aluH),
        .overflow(aluV)
    );

    // ----------------------------------------------------------------
    // wishbone answer
    // ----------------------------------------------------------------
    always_comb begin
        case (wbReq.adr)
            OFF_ACC: next_rdData = {24'h000000, acc};
            OFF_XIDX: next_rdData = {24'h000000, xIdx};
            OFF_YIDX: next_rdData = {24'h000000, yIdx};
            OFF_SP: next_rdData = {24'h000000, sp};
            OFF_PC: next_rdData = {16'h0000, pc};
            OFF_PSW: next_rdData = {24'h000000, processor_status_word};
            OFF_OPND: next_rdData = {16'h0000, opnd};
            OFF_EA: next_rdData = {16'h0000, ea};
            OFF_RAMADR: next_rdData = {23'h000000, ramAdr};
            OFF_RAMDAT: next_rdData = ramInRange ? {24'h000000, ram[ramAdr]} : 32'h00000000;
            OFF_STATUS: next_rdData = {29'h00000000, irqLevel, busy};
            default: next_rdData = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            rdData <= 32'h00000000;
        end else begin
            ack <= wbReq.cyc && wbReq.stb && !ack;
            if (wbReq.cyc && wbReq.stb && !ack && !wbReq.we) begin
                rdData <= next_rdData;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqMeta <= 2'b00;
            irqLevel <= 2'b00;
        end else begin
            irqMeta <= extIrq;
            irqLevel <= irqMeta;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: pushes and vector fetch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_VEC_LO;
            progAddr <= RESET_VEC;
            pushIdx <= 2'd0;
            pushLast <= 2'd1;
            useVec <= 1'b0;
            target <= PC_RESET;
            savedPsw <= PSW_RESET;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (callStart) begin
                        state <= ST_PUSH;
                        pushIdx <= 2'd0;
                        pushLast <= (irqTake || cmdCode == CMD_BRK) ? 2'd2 : 2'd1;
                        savedPsw <= processor_status_word;
                        useVec <= irqTake || cmdCode == CMD_TABLE_CALL_OP || cmdCode == CMD_BRK;
                        if (irqTake) begin
                            target <= irqVec;
                        end else if (cmdCode == CMD_TABLE_CALL_OP) begin
                            target <= tcallVec;
                        end else if (cmdCode == CMD_BRK) begin
                            target <= TABLE_CALL_OP_SLOT0_VEC;
                        end else if (cmdCode == CMD_PAGE_CALL_OP) begin
                            target <= PAGE_CALL_BASE | {8'h00, opnd[7:0]};
                        end else begin
                            target <= opnd;
                        end
                    end
                end
                ST_PUSH: begin
                    pushIdx <= pushIdx + 2'd1;
                    if (pushIdx == pushLast) begin
                        state <= useVec ? ST_VEC_LO : ST_IDLE;
                        progAddr <= target;
                    end
                end
                ST_VEC_LO: begin
                    progAddr <= progAddr + 16'h0001;
                    state <= ST_VEC_HI;
                end
                ST_VEC_HI: state <= ST_VEC_END;
                ST_VEC_END: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RESET;
        end else if (state == ST_VEC_HI) begin
            pc[7:0] <= progData;
        end else if (state == ST_VEC_END) begin
            pc[15:8] <= progData;
        end else if (state == ST_PUSH && pushIdx == pushLast && !useVec) begin
            pc <= target;
        end else if (cmdFire && cmdCode == CMD_INCPC) begin
            pc <= pc + 16'h0001;
        end else if (regWr && wbReq.adr == OFF_PC) begin
            pc <= lane16(pc, wbReq.dat, wbReq.sel);
        end
    end

    // ----------------------------------------------------------------
    // stack pointer and data memory
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sp <= SP_RESET;
        end else if (state == ST_PUSH) begin
            sp <= sp - 8'h01;
        end else if (cmdFire && cmdCode == CMD_TXSP) begin
            sp <= xIdx;
        end else if (regWr && wbReq.adr == OFF_SP) begin
            sp <= wbReq.dat[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (state == ST_PUSH) begin
            ram[{1'b0, sp}] <= pushByte;
        end else if (wbWr && wbReq.sel[0] && wbReq.adr == OFF_RAMDAT && ramInRange) begin
            ram[ramAdr] <= wbReq.dat[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ramAdr <= 9'h000;
        end else if (wbWr && wbReq.adr == OFF_RAMADR) begin
            ramAdr <= 9'(lane16({7'h00, ramAdr}, wbReq.dat, wbReq.sel));
        end
    end

    // ----------------------------------------------------------------
    // accumulator, index registers, operand, effective address
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RESET;
        end else if (cmdFire && (aluOp != ALU_PASS || cmdCode == CMD_LOAD)) begin
            acc <= aluRes;
        end else if (cmdFire && cmdCode == CMD_LDYA) begin
            acc <= opnd[7:0];
        end else if (regWr && wbReq.adr == OFF_ACC) begin
            acc <= wbReq.dat[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xIdx <= IDX_RESET;
        end else if (regWr && wbReq.adr == OFF_XIDX) begin
            xIdx <= wbReq.dat[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            yIdx <= IDX_RESET;
        end else if (cmdFire && cmdCode == CMD_LDYA) begin
            yIdx <= opnd[15:8];
        end else if (regWr && wbReq.adr == OFF_YIDX) begin
            yIdx <= wbReq.dat[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opnd <= 16'h0000;
        end else if (wbWr && !busy && wbReq.adr == OFF_OPND) begin
            opnd <= lane16(opnd, wbReq.dat, wbReq.sel);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ea <= 16'h0000;
        end else if (cmdFire && cmdCode == CMD_EA_DIR) begin
            ea <= {7'h00, processor_status_word.g, opnd[7:0]};
        end else if (cmdFire && cmdCode == CMD_EA_X) begin
            ea <= opnd + {8'h00, xIdx};
        end else if (cmdFire && cmdCode == CMD_EA_Y) begin
            ea <= opnd + {8'h00, yIdx};
        end
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            processor_status_word <= PSW_RESET;
        end else if (irqTake) begin
            processor_status_word.i <= 1'b0;
        end else if (cmdFire) begin
            case (cmdCode)
                CMD_ADD, CMD_SUB: begin
                    processor_status_word.c <= aluC;
                    processor_status_word.h <= aluH;
                    processor_status_word.v <= aluV;
                    processor_status_word.z <= (aluRes == 8'h00);
                    processor_status_word.n <= aluRes[7];
                end
                CMD_SHL, CMD_ROL: begin
                    processor_status_word.c <= aluC;
                    processor_status_word.z <= (aluRes == 8'h00);
                    processor_status_word.n <= aluRes[7];
                end
                CMD_LOAD: begin
                    processor_status_word.z <= (aluRes == 8'h00);
                    processor_status_word.n <= aluRes[7];
                end
                CMD_BIT: begin
                    processor_status_word.n <= opnd[7];
                    processor_status_word.v <= opnd[6];
                    processor_status_word.z <= ((acc & opnd[7:0]) == 8'h00);
                end
                CMD_LDYA: begin
                    processor_status_word.z <= (opnd == 16'h0000);
                    processor_status_word.n <= opnd[15];
                end
                CMD_EI: processor_status_word.i <= 1'b1;
                CMD_DI: processor_status_word.i <= 1'b0;
                CMD_DIRECT_PAGE_HIGH_OP: processor_status_word.g <= 1'b1;
                CMD_DIRECT_PAGE_LOW_OP: processor_status_word.g <= 1'b0;
                CMD_OVERFLOW_CLEAR_OP: begin
                    processor_status_word.v <= 1'b0;
                    processor_status_word.h <= 1'b0;
                end
                CMD_BRK: begin
                    processor_status_word.b <= 1'b1;
                    processor_status_word.i <= 1'b0;
                end
                default: processor_status_word <= processor_status_word;
            endcase
        end else if (regWr && wbReq.adr == OFF_PSW) begin
            // half carry and overflow cannot be written directly
            processor_status_word <= {wbReq.dat[7], processor_status_word.v, wbReq.dat[5:4], processor_status_word.h, wbReq.dat[2:0]};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_two_pushes;
        (state == ST_PUSH) ##1 (state == ST_PUSH);
    endsequence

    property p_reset_vec;
        (state == ST_VEC_END) |=> (pc == {$past(progData), $past(progData, 2)});
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not loaded from vector bytes");

    property p_pc_wrap;
        (cmdFire && cmdCode == CMD_INCPC) |=> (pc == $past(pc) + 16'h0001);
    endproperty
    a_pc_wrap: assert property (p_pc_wrap) else $error("pc increment wrong");

    property p_sp_push;
        (state == ST_PUSH) |=> (sp == $past(sp) - 8'h01);
    endproperty
    a_sp_push: assert property (p_sp_push) else $error("stack pointer not decremented on push");

    property p_irq_entry;
        irqTake |=> (!processor_status_word.i && state == ST_PUSH);
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry did not clear enable");

    property p_irq_gate;
        (state == ST_IDLE && !processor_status_word.i && !cmdFire) |=> (state == ST_IDLE);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken while disabled");

    property p_table_call_op_vec;
        (cmdFire && cmdCode == CMD_TABLE_CALL_OP) |=> s_two_pushes ##1
            (state == ST_VEC_LO && progAddr == $past(tcallVec, 3));
    endproperty
    a_table_call_op_vec: assert property (p_table_call_op_vec) else $error("table call vector wrong");

    property p_brk_flag;
        (cmdFire && cmdCode == CMD_BRK) |=> (processor_status_word.b && !processor_status_word.i);
    endproperty
    a_brk_flag: assert property (p_brk_flag) else $error("break flag not set");

    property p_zero_flag;
        (cmdFire && cmdCode == CMD_LOAD) |=> (processor_status_word.z == ($past(aluRes) == 8'h00));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_dir_page;
        (cmdFire && cmdCode == CMD_EA_DIR) |=> (ea[8] == $past(processor_status_word.g) && ea[15:9] == 7'h00);
    endproperty
    a_dir_page: assert property (p_dir_page) else $error("direct page mapping wrong");

    property p_bit_test;
        (cmdFire && cmdCode == CMD_BIT) |=> (processor_status_word.v == $past(opnd[6]) && processor_status_word.n == $past(opnd[7]));
    endproperty
    a_bit_test: assert property (p_bit_test) else $error("bit test flags wrong");

    property p_half_hold;
        (regWr && wbReq.adr == OFF_PSW) |=> (processor_status_word.h == $past(processor_status_word.h));
    endproperty
    a_half_hold: assert property (p_half_hold) else $error("half carry changed by write");

endmodule : cpu_register_set

/* logic/cpu_regs_pkg.sv */
// constants, types and register map of the cpu register set
// assumes a 100 MHz system clock and a 32-bit classic wishbone slave port
package cpu_regs_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_XIDX = 8'h04;
    localparam logic [7:0] OFF_YIDX = 8'h08;
    localparam logic [7:0] OFF_SP = 8'h0C;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_PSW = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_OPND = 8'h1C;
    localparam logic [7:0] OFF_EA = 8'h20;
    localparam logic [7:0] OFF_RAMADR = 8'h24;
    localparam logic [7:0] OFF_RAMDAT = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2C;

    // ----------------------------------------------------------------
    // command word fields
    // ----------------------------------------------------------------
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_SLOT_LSB = 8;

    // ----------------------------------------------------------------
    // reset values and memory layout
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] RESET_VEC = 16'hFFFE;
    localparam logic [15:0] EXT0_VEC = 16'hFFFA;
    localparam logic [15:0] TABLE_CALL_OP_SLOT0_VEC = 16'hFFDE;
    localparam logic [15:0] PAGE_CALL_BASE = 16'hFF00;
    localparam int DMEM_BYTES = 448;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic n;
        logic v;
        logic g;
        logic b;
        logic h;
        logic i;
        logic z;
        logic c;
    } psw_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    typedef enum logic [4:0] {
        CMD_NOP, CMD_ADD, CMD_SUB, CMD_SHL, CMD_ROL, CMD_LOAD, CMD_BIT,
        CMD_EI, CMD_DI, CMD_DIRECT_PAGE_HIGH_OP, CMD_DIRECT_PAGE_LOW_OP, CMD_OVERFLOW_CLEAR_OP, CMD_CALL, CMD_PAGE_CALL_OP,
        CMD_TABLE_CALL_OP, CMD_BRK, CMD_INCPC, CMD_TXSP, CMD_EA_DIR, CMD_EA_X,
        CMD_EA_Y, CMD_LDYA
    } cmd_e;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_SHL, ALU_ROL, ALU_PASS
    } alu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PUSH, ST_VEC_LO, ST_VEC_HI, ST_VEC_END
    } state_e;

endpackage : cpu_regs_pkg

/* logic/alu_flag_unit.sv */
// 8-bit adder/shifter producing result, carry, half carry and overflow
// assumes operands come from registers on the same clock
`timescale 1ns/1ps
module alu_flag_unit (
    // operation
    input wire cpu_regs_pkg::alu_op_e aluOp,
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    // results
    output logic [7:0] result,
    output logic carryOut,
    output logic halfCarry,
    output logic overflow
);
    import cpu_regs_pkg::*;

    logic [7:0] bEff;
    logic [8:0] sum9;
    logic [4:0] low5;

    always_comb begin
        bEff = (aluOp == ALU_SUB) ? ~opB : opB;
        sum9 = 9'h000;
        low5 = 5'h00;
        case (aluOp)
            ALU_ADD, ALU_SUB: begin
                sum9 = {1'b0, opA} + {1'b0, bEff} + {8'h00, carryIn};
                low5 = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, carryIn};
            end
            ALU_SHL: sum9 = {opA, 1'b0};
            ALU_ROL: sum9 = {opA, carryIn};
            ALU_PASS: sum9 = {1'b0, opB};
            default: sum9 = 9'h000;
        endcase
        result = sum9[7:0];
        carryOut = sum9[8];
        halfCarry = low5[4];
        overflow = (aluOp == ALU_ADD || aluOp == ALU_SUB) && (opA[7] == bEff[7]) && (sum9[7] != opA[7]);
    end

endmodule : alu_flag_unit

/* verif/tb_cpu_register_set.sv */
// self-checking bench for the cpu register set over classic wishbone
// assumes a sync rom model that returns the inverted low address byte one cycle later
`timescale 1ns/1ps
module tb_cpu_register_set;
    import cpu_regs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    wb_req_s wbReq = '0;
    wb_rsp_s wbRsp;
    logic [15:0] progAddr;
    logic progRead;
    logic [7:0] progData = 8'h00;
    logic [1:0] extIrq = 2'h0;
    logic busy;
    logic [31:0] rdData;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    cpu_register_set dut (.clk_sys(clk_sys), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
        .progAddr(progAddr), .progRead(progRead), .progData(progData), .extIrq(extIrq), .busy(busy));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) progData <= ~progAddr[7:0];
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // expected pc after a jump through the vector at v
    function automatic logic [31:0] vp(input logic [15:0] v);
        return {16'h0, ~v[7:1], 1'b0, ~v[7:1], 1'b1};
    endfunction : vp
    task automatic access(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wbReq <= '{1'b1, 1'b1, we, 4'hF, a, d};
        @(posedge clk_sys);
        while (wbRsp.ack !== 1'b1) @(posedge clk_sys);
        rdData = wbRsp.dat;
        wbReq <= '0;
    endtask : access
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        chk(rdData, exp);
    endtask : rdchk
    task automatic ex(input logic [15:0] opnd, input cmd_e c, input logic [3:0] slot);
        access(1'b1, OFF_OPND, {16'h0, opnd});
        access(1'b1, OFF_CMD, {20'h0, slot, 3'h0, c});
        @(posedge clk_sys);
        while (busy !== 1'b0) @(posedge clk_sys);
    endtask : ex
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        while (busy !== 1'b0) @(posedge clk_sys);
        rdchk(OFF_PC, vp(16'hFFFE));
        access(1'b1, OFF_PSW, 32'hFF);
        rdchk(OFF_PSW, 32'hB7);
        access(1'b1, OFF_PSW, 32'h00);
        ex(16'h000F, CMD_LOAD, 4'h0);
        ex(16'h0001, CMD_ADD, 4'h0);
        rdchk(OFF_PSW, 32'h08);
        ex(16'h0080, CMD_LOAD, 4'h0);
        rdchk(OFF_PSW, 32'h88);
        ex(16'h0080, CMD_ADD, 4'h0);
        rdchk(OFF_ACC, 32'h00);
        rdchk(OFF_PSW, 32'h43);
        ex(16'h0000, CMD_OVERFLOW_CLEAR_OP, 4'h0);
        rdchk(OFF_PSW, 32'h03);
        ex(16'h00C0, CMD_BIT, 4'h0);
        rdchk(OFF_PSW, 32'hC3);
        ex(16'h0000, CMD_OVERFLOW_CLEAR_OP, 4'h0);
        access(1'b1, OFF_PSW, 32'h00);
        ex(16'h0000, CMD_DIRECT_PAGE_HIGH_OP, 4'h0);
        ex(16'h0000, CMD_EI, 4'h0);
        rdchk(OFF_PSW, 32'h24);
        ex(16'h0000, CMD_DIRECT_PAGE_LOW_OP, 4'h0);
        ex(16'h0000, CMD_DI, 4'h0);
        rdchk(OFF_PSW, 32'h00);
        access(1'b1, OFF_SP, 32'hBF);
        for (int s = 0; s <= 15; s += 15) begin
            ex(16'h0000, CMD_TABLE_CALL_OP, 4'(s));
            chk({15'h0, progRead, progAddr}, 32'hFFC1 + 32'(2 * (15 - s)));
            rdchk(OFF_PC, vp(16'hFFC0 + 16'(2 * (15 - s))));
        end
        rdchk(OFF_SP, 32'hBB);
        ex(16'h0000, CMD_EI, 4'h0);
        ex(16'h0000, CMD_BRK, 4'h0);
        rdchk(OFF_PSW, 32'h10);
        rdchk(OFF_PC, vp(16'hFFDE));
        for (int i = 0; i < 2; i++) begin
            ex(16'h0000, CMD_EI, 4'h0);
            extIrq <= 2'(1 << i);
            while (busy !== 1'b1) @(posedge clk_sys);
            extIrq <= 2'h0;
            while (busy !== 1'b0) @(posedge clk_sys);
            rdchk(OFF_PC, vp(16'hFFFA - 16'(2 * i)));
            rdchk(OFF_PSW, 32'h10);
            rdchk(OFF_SP, 32'hB5 - 32'(3 * i));
        end
        ex(16'h0035, CMD_PAGE_CALL_OP, 4'h0);
        rdchk(OFF_PC, 32'hFF35);
        access(1'b1, OFF_PC, 32'hFFFF);
        ex(16'h0000, CMD_INCPC, 4'h0);
        rdchk(OFF_PC, 32'h0000);
        access(1'b1, OFF_XIDX, 32'h10);
        ex(16'h0120, CMD_EA_X, 4'h0);
        rdchk(OFF_EA, 32'h0130);
        ex(16'h1234, CMD_LDYA, 4'h0);
        rdchk(OFF_YIDX, 32'h12);
        rdchk(OFF_ACC, 32'h34);
        access(1'b1, OFF_RAMADR, 32'h1BF);
        access(1'b1, OFF_RAMDAT, 32'h5A);
        rdchk(OFF_RAMDAT, 32'h5A);
        access(1'b1, OFF_RAMADR, 32'h1C0);
        rdchk(OFF_RAMDAT, 32'h00);
        ex(16'h0000, CMD_DIRECT_PAGE_HIGH_OP, 4'h0);
        ex(16'h0055, CMD_EA_DIR, 4'h0);
        rdchk(OFF_EA, 32'h0155);
        ex(16'h0100, CMD_EA_Y, 4'h0);
        rdchk(OFF_EA, 32'h0112);
        ex(16'h0010, CMD_SUB, 4'h0);
        rdchk(OFF_ACC, 32'h23);
        rdchk(OFF_PSW, 32'h39);
        ex(16'h0000, CMD_ROL, 4'h0);
        rdchk(OFF_ACC, 32'h47);
        ex(16'h0081, CMD_LOAD, 4'h0);
        ex(16'h0000, CMD_SHL, 4'h0);
        ex(16'h0000, CMD_NOP, 4'h0);
        rdchk(OFF_PSW, 32'h39);
        access(1'b1, OFF_XIDX, 32'hBF);
        ex(16'h0000, CMD_TXSP, 4'h0);
        rdchk(OFF_SP, 32'hBF);
        access(1'b1, OFF_PC, 32'hABCD);
        ex(16'h1234, CMD_CALL, 4'h0);
        rdchk(OFF_PC, 32'h1234);
        access(1'b1, OFF_RAMADR, 32'hBF);
        rdchk(OFF_RAMDAT, 32'hAB);
        access(1'b1, OFF_RAMADR, 32'hBE);
        rdchk(OFF_RAMDAT, 32'hCD);
        extIrq <= 2'h2;
        repeat (3) @(posedge clk_sys);
        rdchk(OFF_STATUS, 32'h4);
        rdchk(OFF_SP, 32'hBD);
        extIrq <= 2'h0;
        rdchk(8'h30, 32'h0);
        finish_test();
    end
endmodule : tb_cpu_register_set
